// ---- logic/pisms_pkg.sv ----
// Constants for the interrupt status, mask and sense block
package pisms_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the serial port)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_STATUS0 = 6'h00;
  localparam logic [5:0] ADDR_MASK0 = 6'h01;
  localparam logic [5:0] ADDR_SENSE0 = 6'h02;
  localparam logic [5:0] ADDR_STATUS1 = 6'h03;
  localparam logic [5:0] ADDR_MASK1 = 6'h04;

  localparam int DATA_W = 24;
  localparam int ADDR_W = 6;

  // ----------------------------------------------------------------
  // Serial frame layout: write flag, address, spare, data
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 8;
  localparam logic [5:0] FRAME_LAST = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h08;
  localparam int FRM_WR_POS = 31;
  localparam int FRM_ADDR_LSB = 25;
  localparam int HDR_WR_POS = 7;
  localparam int HDR_ADDR_LSB = 1;

  // ----------------------------------------------------------------
  // Bank 0 field positions
  // ----------------------------------------------------------------
  localparam int B0_CONV_DONE = 0;
  localparam int B0_TOUCH_DONE = 1;
  localparam int B0_PEN = 2;
  localparam int B0_OVP = 5;
  localparam int B0_BATT_LOW = 13;
  localparam int B0_KEY_PRESS = 17;
  localparam int B0_LONG_PRESS = 18;
  localparam int B0_LONG_REL = 19;
  localparam int B0_UNKNOWN_ACC = 20;
  localparam int B0_ACC_CHANGE = 21;
  localparam int B0_KEY_STUCK = 22;
  localparam int B0_KEY_UNJAM = 23;
  localparam int S0_SUPPLY_DONE = 17;
  localparam int S0_IDRES_DONE = 18;
  localparam int S0_ID_GND = 20;
  localparam int S0_ACC_CONV = 21;

  // ----------------------------------------------------------------
  // Bank 1 field positions
  // ----------------------------------------------------------------
  localparam int B1_WDOG_RST = 5;
  localparam int B1_BTN_RST = 6;
  localparam int B1_DIE_TEMP = 11;

  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] STATUS0_MAIN_BITS = 24'h002027;
  localparam logic [23:0] STATUS0_ACC_BITS = 24'hFE0000;
  localparam logic [23:0] MASK0_BITS = 24'hFE2027;
  localparam logic [23:0] MASK0_RESET = 24'hFE2007;
  localparam logic [23:0] STATUS1_BKP_BITS = 24'h000060;
  localparam logic [23:0] STATUS1_MAIN_BITS = 24'h000800;
  localparam logic [23:0] MASK1_RESET = 24'h000860;

endpackage : pisms_pkg

// ---- logic/pisms_core.sv ----
// Interrupt status, mask and sense registers behind a serial register port
// Functional notes
// - Conversion-done sets status0 bit 0; write one clears; main reset zeroes.
// - Touch conversion done sets status0 bit 1; write one clears.
// - Pen contact sets status0 bit 2; write one clears.
// - Overvoltage event latches status0 bit 5; live level on sense0 bit 5.
// - Low battery sets status0 bit 13; cleared by write one or main reset.
// - Key press sets status0 bit 17; cleared by write one or accessory reset.
// - Long press sets bit 18; its release sets bit 19.
// - Unrecognised accessory attach sets status0 bit 20.
// - Accessory result change sets bit 21 only while unfiltered select is 0.
// - Stuck remote key sets status0 bit 22.
// - Stuck key recovery sets status0 bit 23.
// - Every event has a mask bit; pen mask and most masks reset to one.
// - Sense bit 20 shows grounded ID line; accessory reset clears it.
// - Sense bit 21 is one when accessory conversion completed, zero meanwhile.
// - Sense bit 17 shows supply type identification done.
// - Sense bit 18 shows ID resistance detection done.
// - Status1 bits 5 and 6 flag watchdog and button resets; backup reset clears.
// - Die temperature crossing sets status1 bit 11; write one clears.
`timescale 1ns/1ps
module pisms_core
  import pisms_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic off_rst_n_i,
  input wire logic accessory_block_reset_n_i,
  input wire logic backup_domain_reset_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic conv_done_i,
  input wire logic touch_conv_done_i,
  input wire logic pen_contact_i,
  input wire logic vbus_overvoltage_i,
  input wire logic vbus_overvoltage_live_i,
  input wire logic battery_low_i,
  input wire logic remote_key_press_i,
  input wire logic remote_long_press_i,
  input wire logic remote_long_release_i,
  input wire logic unrecognised_accessory_i,
  input wire logic accessory_result_change_i,
  input wire logic unfiltered_result_select_i,
  input wire logic key_stuck_i,
  input wire logic key_unjammed_i,
  input wire logic id_line_grounded_live_i,
  input wire logic accessory_conv_state_i,
  input wire logic supply_type_done_live_i,
  input wire logic id_resistance_done_live_i,
  input wire logic watchdog_reset_i,
  input wire logic button_reset_i,
  input wire logic die_temp_first_i,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cs_sync_ff;
  logic [2:0] sclk_sync_ff;
  logic [1:0] mosi_sync_ff;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cs_sync_ff <= 3'h7;
      sclk_sync_ff <= 3'h0;
      mosi_sync_ff <= 2'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], spi_cs_n_i};
      sclk_sync_ff <= {sclk_sync_ff[1:0], spi_sclk_i};
      mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi_i};
    end
  end

  // Edges only look at the second and third stages
  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;
  logic cs_end;
  assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign cs_act = ~cs_sync_ff[1];
  assign cs_end = cs_sync_ff[1] & ~cs_sync_ff[2];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] status0_ff;
  logic [DATA_W-1:0] mask0_ff;
  logic [DATA_W-1:0] sense0_ff;
  logic [DATA_W-1:0] status1_ff;
  logic [DATA_W-1:0] mask1_ff;

  function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] addr,
                                                 input logic [DATA_W-1:0] st0,
                                                 input logic [DATA_W-1:0] m0,
                                                 input logic [DATA_W-1:0] se0,
                                                 input logic [DATA_W-1:0] st1,
                                                 input logic [DATA_W-1:0] m1);
    logic [DATA_W-1:0] val;
    val = '0;
    case (addr)
      ADDR_STATUS0: val = st0;
      ADDR_MASK0: val = m0;
      ADDR_SENSE0: val = se0;
      ADDR_STATUS1: val = st1;
      ADDR_MASK1: val = m1;
      default: val = '0;
    endcase
    return val;
  endfunction : reg_read

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_ff;
  logic [DATA_W-1:0] tx_ff;
  logic [5:0] bit_cnt_ff;
  logic miso_ff;
  logic miso_oe_ff;
  logic [FRAME_BITS-1:0] nxt_rx;
  assign nxt_rx = {rx_ff[FRAME_BITS-2:0], mosi_sync_ff[1]};

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_ff <= '0;
      bit_cnt_ff <= 6'h00;
    end else if (!cs_act) begin
      bit_cnt_ff <= 6'h00;
    end else if (sclk_rise && bit_cnt_ff != FRAME_LAST) begin
      rx_ff <= nxt_rx;
      bit_cnt_ff <= bit_cnt_ff + 6'h01;
    end
  end

  // Read data is snapped once the header is in, so a later event
  // cannot tear the word that is being shifted out
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_ff <= '0;
    end else if (cs_act && sclk_rise && bit_cnt_ff == HDR_LAST - 6'h01) begin
      tx_ff <= reg_read(nxt_rx[HDR_ADDR_LSB +: ADDR_W], status0_ff, mask0_ff,
                        sense0_ff, status1_ff, mask1_ff);
    end else if (cs_act && sclk_fall && bit_cnt_ff >= HDR_LAST
                 && bit_cnt_ff != FRAME_LAST) begin
      tx_ff <= {tx_ff[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= cs_act;
      if (!cs_act) begin
        miso_ff <= 1'b0;
      end else if (sclk_fall && bit_cnt_ff >= HDR_LAST && bit_cnt_ff != FRAME_LAST) begin
        miso_ff <= tx_ff[DATA_W-1];
      end
    end
  end

  assign spi_miso_o = miso_ff;
  assign spi_miso_oe_o = miso_oe_ff;

  // Writes land only when a complete frame closed; short frames are dropped
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  assign wr_stb = cs_end && bit_cnt_ff == FRAME_LAST && rx_ff[FRM_WR_POS];
  assign wr_addr = rx_ff[FRM_ADDR_LSB +: ADDR_W];
  assign wr_data = rx_ff[DATA_W-1:0];

  logic [DATA_W-1:0] clr0;
  logic [DATA_W-1:0] clr1;
  assign clr0 = (wr_stb && wr_addr == ADDR_STATUS0) ? wr_data : '0;
  assign clr1 = (wr_stb && wr_addr == ADDR_STATUS1) ? wr_data : '0;

  // ----------------------------------------------------------------
  // Bank 0 status
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] set0;
  always_comb begin
    set0 = '0;
    set0[B0_CONV_DONE] = conv_done_i;
    set0[B0_TOUCH_DONE] = touch_conv_done_i;
    set0[B0_PEN] = pen_contact_i;
    set0[B0_OVP] = vbus_overvoltage_i;
    set0[B0_BATT_LOW] = battery_low_i;
    set0[B0_KEY_PRESS] = remote_key_press_i;
    set0[B0_LONG_PRESS] = remote_long_press_i;
    set0[B0_LONG_REL] = remote_long_release_i;
    set0[B0_UNKNOWN_ACC] = unrecognised_accessory_i;
    set0[B0_ACC_CHANGE] = accessory_result_change_i & ~unfiltered_result_select_i;
    set0[B0_KEY_STUCK] = key_stuck_i;
    set0[B0_KEY_UNJAM] = key_unjammed_i;
  end

  // main reset domain; set wins over a same-cycle clear
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      status0_ff[15:0] <= '0;
    end else begin
      status0_ff[15:0] <= ((status0_ff[15:0] & ~clr0[15:0]) | set0[15:0])
                          & STATUS0_MAIN_BITS[15:0];
    end
  end

  // accessory reset domain for the remote and attach flags
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !accessory_block_reset_n_i) begin
      status0_ff[23:16] <= '0;
    end else begin
      status0_ff[23:16] <= ((status0_ff[23:16] & ~clr0[23:16]) | set0[23:16])
                           & STATUS0_ACC_BITS[23:16];
    end
  end

  // ----------------------------------------------------------------
  // Bank 0 sense
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    sense0_ff[16:0] <= '0;
    sense0_ff[23:19] <= '0;
    if (rst_n_i) begin
      sense0_ff[B0_OVP] <= vbus_overvoltage_live_i;
      sense0_ff[S0_ACC_CONV] <= accessory_conv_state_i;
      // grounded ID line, held low in accessory reset
      sense0_ff[S0_ID_GND] <= accessory_block_reset_n_i & id_line_grounded_live_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !accessory_block_reset_n_i) begin
      sense0_ff[18:17] <= 2'h0;
    end else begin
      sense0_ff[S0_SUPPLY_DONE] <= supply_type_done_live_i;
      sense0_ff[S0_IDRES_DONE] <= id_resistance_done_live_i;
    end
  end

  // ----------------------------------------------------------------
  // Masks
  // ----------------------------------------------------------------
  // masks reset to one except overvoltage; reserved bits stay zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mask0_ff <= MASK0_RESET;
    end else if (wr_stb && wr_addr == ADDR_MASK0) begin
      mask0_ff <= wr_data & MASK0_BITS;
    end
  end

  // Reset-cause masks sit in the backup domain, the thermal mask in main
  always_ff @(posedge mclk_i) begin
    if (!backup_domain_reset_n_i) begin
      mask1_ff[10:0] <= MASK1_RESET[10:0];
    end else if (wr_stb && wr_addr == ADDR_MASK1) begin
      mask1_ff[10:0] <= wr_data[10:0] & STATUS1_BKP_BITS[10:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mask1_ff[23:11] <= MASK1_RESET[23:11];
    end else if (wr_stb && wr_addr == ADDR_MASK1) begin
      mask1_ff[23:11] <= wr_data[23:11] & STATUS1_MAIN_BITS[23:11];
    end
  end

  // ----------------------------------------------------------------
  // Bank 1 status
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] set1;
  always_comb begin
    set1 = '0;
    set1[B1_WDOG_RST] = watchdog_reset_i;
    set1[B1_BTN_RST] = button_reset_i;
    set1[B1_DIE_TEMP] = die_temp_first_i;
  end

  // reset-cause flags survive the main reset so software can read them
  always_ff @(posedge mclk_i) begin
    if (!backup_domain_reset_n_i) begin
      status1_ff[10:0] <= '0;
    end else begin
      status1_ff[10:0] <= ((status1_ff[10:0] & ~clr1[10:0]) | set1[10:0])
                          & STATUS1_BKP_BITS[10:0];
    end
  end

  // write one clears the thermal flag
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      status1_ff[23:11] <= '0;
    end else begin
      status1_ff[23:11] <= ((status1_ff[23:11] & ~clr1[23:11]) | set1[23:11])
                           & STATUS1_MAIN_BITS[23:11];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  logic irq_ff;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status0_ff & ~mask0_ff) | |(status1_ff & ~mask1_ff);
    end
  end
  assign irq_o = irq_ff;

endmodule : pisms_core

// ---- test/pisms_core_props.sv ----
// Port checker for the interrupt status, mask and sense block
`timescale 1ns/1ps
module pisms_core_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic accessory_block_reset_n_i,
  input wire logic backup_domain_reset_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic vbus_overvoltage_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_RST_OUT: assert property ($rose(rst_n_i) |-> !irq_o && !spi_miso_oe_o && !spi_miso_o)
    else $error("outputs not idle after reset");
  AST_OE_IDLE: assert property (spi_cs_n_i [*4] |-> !spi_miso_oe_o)
    else $error("miso driven with select high");
  AST_OE_ACTIVE: assert property (!spi_cs_n_i [*4] |-> spi_miso_oe_o)
    else $error("miso not driven with select low");
  AST_OE_RISE: assert property ($rose(spi_miso_oe_o) |-> !$past(spi_cs_n_i, 2))
    else $error("miso enable rose without select");
  // Data bit moves only after a falling serial clock
  AST_MISO_HOLD: assert property (spi_miso_oe_o && spi_sclk_i && $past(spi_sclk_i)
    |-> $stable(spi_miso_o)) else $error("miso changed while clock high");
  AST_OVP_IRQ: assert property (vbus_overvoltage_i |-> ##2 irq_o)
    else $error("overvoltage event gave no request");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(spi_cs_n_i, 2)
    || !$past(accessory_block_reset_n_i, 2) || !$past(backup_domain_reset_n_i, 2))
    else $error("request dropped without clear");
  AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(spi_cs_n_i, 2))
    else $error("request rose during a frame");
  cover property ($rose(irq_o));
  cover property ($fell(irq_o));
  cover property ($rose(spi_miso_oe_o));
endmodule : pisms_core_props

bind pisms_core pisms_core_props u_pisms_core_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .accessory_block_reset_n_i(accessory_block_reset_n_i),
  .backup_domain_reset_n_i(backup_domain_reset_n_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_sclk_i(spi_sclk_i), .vbus_overvoltage_i(vbus_overvoltage_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .irq_o(irq_o));

// ---- test/pisms_host.sv ----
// Host model issuing serial register frames
`timescale 1ns/1ps
module pisms_host (
  input wire logic mclk_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // Phases of 5 clocks stay above the 4-clock floor of the synchroniser
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [23:0] d,
                      output logic [23:0] q);
    logic [31:0] f;
    f = {wr, a, 1'b0, d};
    q = 24'h000000;
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi_o = f[i];
      repeat (5) @(negedge mclk_i);
      if (i < 24) q[i] = miso_i;
      sclk_o = 1'b1;
      repeat (5) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
    repeat (5) @(negedge mclk_i);
    cs_n_o = 1'b1;
    // Released line flips so a stale level never looks like data
    mosi_o = ~mosi_o;
    repeat (8) @(negedge mclk_i);
  endtask : xfer
endmodule : pisms_host

// ---- test/pisms_core_tb.sv ----
// Self-checking bench for the interrupt status, mask and sense block
`timescale 1ns/1ps
module pisms_core_tb;
  import pisms_pkg::*;
  logic mclk_i;
  logic rst_n_i;
  logic acc_rst_n;
  logic bkp_rst_n;
  logic cs_n, sclk, mosi, miso, miso_oe, irq, unf_sel;
  logic [14:0] ev;
  logic [4:0] lv;
  int error_cnt;
  int check_count;
  localparam int POS [15] = '{0, 1, 2, 5, 13, 17, 18, 19, 20, 21, 22, 23, 5, 6, 11};

  pisms_core u_pisms_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .off_rst_n_i(1'b1),
    .accessory_block_reset_n_i(acc_rst_n), .backup_domain_reset_n_i(bkp_rst_n),
    .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .conv_done_i(ev[0]), .touch_conv_done_i(ev[1]),
    .pen_contact_i(ev[2]), .vbus_overvoltage_i(ev[3]), .vbus_overvoltage_live_i(lv[0]),
    .battery_low_i(ev[4]), .remote_key_press_i(ev[5]), .remote_long_press_i(ev[6]),
    .remote_long_release_i(ev[7]), .unrecognised_accessory_i(ev[8]),
    .accessory_result_change_i(ev[9]), .unfiltered_result_select_i(unf_sel),
    .key_stuck_i(ev[10]), .key_unjammed_i(ev[11]), .id_line_grounded_live_i(lv[1]),
    .accessory_conv_state_i(lv[2]), .supply_type_done_live_i(lv[3]),
    .id_resistance_done_live_i(lv[4]), .watchdog_reset_i(ev[12]),
    .button_reset_i(ev[13]), .die_temp_first_i(ev[14]), .irq_o(irq));
  pisms_host u_pisms_host (.mclk_i(mclk_i), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk),
    .mosi_o(mosi));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] q;
    u_pisms_host.xfer(1'b0, a, 24'h000000, q);
    chk(q, exp);
  endtask : rd_chk

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] q;
    u_pisms_host.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic pulse(input int k);
    ev[k] = 1'b1;
    @(negedge mclk_i);
    ev[k] = 1'b0;
    @(negedge mclk_i);
  endtask : pulse

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : wait_n

  task automatic s_reset();
    rd_chk(ADDR_MASK0, MASK0_RESET);
    rd_chk(ADDR_MASK1, MASK1_RESET);
    rd_chk(ADDR_STATUS0, 24'h000000);
    rd_chk(ADDR_STATUS1, 24'h000000);
    wr(6'h3F, 24'hFFFFFF);
    rd_chk(6'h3F, 24'h000000);
    chk({23'h0, irq}, 24'h000000);
    chk({23'h0, miso_oe}, 24'h000000);
  endtask : s_reset

  // each event sets and clears its own bit
  task automatic s_events();
    logic [23:0] b;
    logic [5:0] a;
    for (int k = 0; k < 15; k++) begin
      b = 24'h000001 << POS[k];
      a = (k < 12) ? ADDR_STATUS0 : ADDR_STATUS1;
      pulse(k);
      rd_chk(a, b);
      chk({23'h0, irq}, {23'h0, k == 3});
      wr(a, b);
      rd_chk(a, 24'h000000);
      chk({23'h0, irq}, 24'h000000);
    end
  endtask : s_events

  task automatic s_partial();
    unf_sel = 1'b1;
    pulse(9);
    pulse(0);
    pulse(2);
    unf_sel = 1'b0;
    rd_chk(ADDR_STATUS0, 24'h000005);
    wr(ADDR_STATUS0, 24'h000001);
    rd_chk(ADDR_STATUS0, 24'h000004);
    wr(ADDR_STATUS0, 24'h000004);
  endtask : s_partial

  task automatic s_sense();
    lv = 5'h1F;
    wait_n(2);
    rd_chk(ADDR_SENSE0, 24'h360020);
    wr(ADDR_SENSE0, 24'hFFFFFF);
    acc_rst_n = 1'b0;
    rd_chk(ADDR_SENSE0, 24'h200020);
    acc_rst_n = 1'b1;
    lv = 5'h00;
    wait_n(2);
    rd_chk(ADDR_SENSE0, 24'h000000);
  endtask : s_sense

  task automatic s_domains();
    pulse(5);
    pulse(12);
    pulse(13);
    pulse(4);
    acc_rst_n = 1'b0;
    wait_n(3);
    acc_rst_n = 1'b1;
    rd_chk(ADDR_STATUS0, 24'h002000);
    rst_n_i = 1'b0;
    wait_n(4);
    rst_n_i = 1'b1;
    wait_n(1);
    rd_chk(ADDR_STATUS0, 24'h000000);
    rd_chk(ADDR_STATUS1, 24'h000060);
    bkp_rst_n = 1'b0;
    wait_n(3);
    bkp_rst_n = 1'b1;
    rd_chk(ADDR_STATUS1, 24'h000000);
  endtask : s_domains

  task automatic s_mask();
    wr(ADDR_MASK0, 24'hFFFFFF);
    rd_chk(ADDR_MASK0, MASK0_BITS);
    wr(ADDR_MASK0, 24'hFE2003);
    pulse(2);
    chk({23'h0, irq}, 24'h000001);
    wr(ADDR_MASK0, MASK0_RESET);
    chk({23'h0, irq}, 24'h000000);
    wr(ADDR_STATUS0, 24'h000004);
    rd_chk(ADDR_STATUS0, 24'h000000);
  endtask : s_mask

  initial begin
    repeat (100000) @(posedge mclk_i);
    error_cnt++;
    conclude();
  end

  initial begin
    rst_n_i = 1'b0;
    acc_rst_n = 1'b0;
    bkp_rst_n = 1'b0;
    ev = 15'h0000;
    lv = 5'h00;
    unf_sel = 1'b0;
    error_cnt = 0;
    check_count = 0;
    wait_n(8);
    rst_n_i = 1'b1;
    acc_rst_n = 1'b1;
    bkp_rst_n = 1'b1;
    wait_n(1);
    s_reset();
    s_events();
    s_partial();
    s_sense();
    s_domains();
    s_mask();
    conclude();
  end
endmodule : pisms_core_tb
